// >>> rtl/sehl_pkg.sv
// constants shared by the error header log and its read port
package sehl_pkg;
   // config offsets of the four log words
   localparam logic [11:0] OFS_WORD0     = 12'h13c;
   localparam logic [11:0] OFS_WORD1     = 12'h140;
   localparam logic [11:0] OFS_WORD2     = 12'h144;
   localparam logic [11:0] OFS_WORD3     = 12'h148;
   // word1 field positions (log bits 39:36 and 43:40)
   localparam int          CMD_LO_LSB    = 4;
   localparam int          CMD_HI_LSB    = 8;
   localparam int          CMD_WIDTH     = 4;
   // value of every log word after reset
   localparam logic [31:0] LOG_RESET     = 32'h0000_0000;
   localparam logic [3:0]  CMD_RESET     = 4'h0;
   // cycles from a taken access to its acknowledge
   localparam int          READ_LATENCY  = 2;
   // index of each word in the log
   typedef enum logic [1:0] {
      WORD_ATTR = 2'b00,
      WORD_CMD  = 2'b01,
      WORD_ALO  = 2'b10,
      WORD_AHI  = 2'b11
   } sehl_word_e;
endpackage

// >>> rtl/sehl_log_if.sv
// link between the access logic and the log storage
`timescale 1ns/1ns
interface sehl_log_if;
   logic                  fundamental_reset_n_n;     // fundamental reset, low active
   logic                  cap_valid;  // one-cycle capture strobe
   logic                  cap_dual;   // two address phases
   logic [31:0]           cap_ad_lo;  // first phase address
   logic [31:0]           cap_ad_hi;  // second phase address
   logic [3:0]            cap_cbe_lo; // first phase command
   logic [3:0]            cap_cbe_hi; // second phase command
   logic                  rd_en;      // word read request
   sehl_pkg::sehl_word_e  rd_index;   // word selected
   logic [31:0]           rd_data;    // registered read data

   modport core  (output fundamental_reset_n_n, cap_valid, cap_dual, cap_ad_lo,
                  cap_ad_hi, cap_cbe_lo, cap_cbe_hi, rd_en, rd_index,
                  input rd_data);
   modport store (input fundamental_reset_n_n, cap_valid, cap_dual, cap_ad_lo,
                  cap_ad_hi, cap_cbe_lo, cap_cbe_hi, rd_en, rd_index,
                  output rd_data);
endinterface

// >>> rtl/sehl_log_store.sv
// storage of the captured header log with registered read data
`timescale 1ns/1ns
module sehl_log_store (
   input  wire logic CLK,     // system clock
   sehl_log_if.store lif      // capture and read port
);
   logic [31:0] addr_lo_q;
   logic [31:0] addr_hi_q;
   logic [3:0]  cmd_lo_q;
   logic [3:0]  cmd_hi_q;
   logic [31:0] rd_data_q;

   // latest error always overwrites, cleared only by fundamental reset
   always_ff @(posedge CLK) begin
      if (!lif.fundamental_reset_n_n) begin
         addr_lo_q <= sehl_pkg::LOG_RESET;
         addr_hi_q <= sehl_pkg::LOG_RESET;
         cmd_lo_q  <= sehl_pkg::CMD_RESET;
         cmd_hi_q  <= sehl_pkg::CMD_RESET;
      end else if (lif.cap_valid) begin
         addr_lo_q <= lif.cap_ad_lo;
         addr_hi_q <= lif.cap_dual ? lif.cap_ad_hi
                                   : sehl_pkg::LOG_RESET;
         cmd_lo_q  <= lif.cap_cbe_lo;
         cmd_hi_q  <= lif.cap_dual ? lif.cap_cbe_hi
                                   : sehl_pkg::CMD_RESET;
      end
   end

   // read mux, zero when idle so a write or miss returns zero
   always_ff @(posedge CLK) begin
      if (!lif.fundamental_reset_n_n) begin
         rd_data_q <= sehl_pkg::LOG_RESET;
      end else if (!lif.rd_en) begin
         rd_data_q <= sehl_pkg::LOG_RESET;
      end else begin
         rd_data_q <= sehl_pkg::LOG_RESET;
         unique case (lif.rd_index)
            sehl_pkg::WORD_ATTR: begin
               rd_data_q <= sehl_pkg::LOG_RESET;
            end
            sehl_pkg::WORD_CMD: begin
               // upper bits stay zero, reserved field
               rd_data_q[sehl_pkg::CMD_LO_LSB +: sehl_pkg::CMD_WIDTH]
                  <= cmd_lo_q;
               rd_data_q[sehl_pkg::CMD_HI_LSB +: sehl_pkg::CMD_WIDTH]
                  <= cmd_hi_q;
            end
            sehl_pkg::WORD_ALO: begin
               rd_data_q <= addr_lo_q;
            end
            sehl_pkg::WORD_AHI: begin
               rd_data_q <= addr_hi_q;
            end
         endcase
      end
   end

   assign lif.rd_data = rd_data_q;
endmodule

// >>> rtl/sehl_header_log.sv
// secondary error header log: capture staging and config read port
//
// Overview of operation
// - latest error capture overwrites earlier log contents
// - words 31:0 at 13Ch, 63:32 at 140h
// - words 95:64 at 144h, 127:96 at 148h
// - first phase AD to 95:64, second 127:96
// - single address phase writes zero to 127:96
// - first phase command stored in bits 39:36
// - dual cycle second phase command in 43:40
// - reserved bits 63:44 always read zero
// - attribute bits 35:0 always read zero
// - log cleared only by fundamental reset
// - all words read-only, zero after reset
`timescale 1ns/1ns
module sehl_header_log (
   input  wire logic        CLK,              // 100 MHz clock
   input  wire logic        RESET_N,          // access logic reset
   input  wire logic        PLATFORM_RESET_N, // platform reset
   input  wire logic        GLOBAL_RESET_N,   // global reset
   input  wire logic        ERR_CAPTURE,      // error strobe
   input  wire logic        ERR_DUAL,         // dual address cycle
   input  wire logic [31:0] ERR_AD_FIRST,     // first phase AD
   input  wire logic [31:0] ERR_AD_SECOND,    // second phase AD
   input  wire logic [3:0]  ERR_CBE_FIRST,    // first phase C/BE
   input  wire logic [3:0]  ERR_CBE_SECOND,   // second phase C/BE
   input  wire logic        CFG_RD,           // config read strobe
   input  wire logic        CFG_WR,           // config write strobe
   input  wire logic [11:0] CFG_ADDR,         // extended byte offset
   input  wire logic [31:0] CFG_WDATA,        // write data, unused
   output logic             CFG_ACK,          // access done pulse
   output logic [31:0]      CFG_RDATA         // read data
);
   sehl_log_if lif ();

   // reset nets
   logic                 fundamental_reset_n;
   logic                 bus_rst_n;
   // access pipeline
   logic [2:0]           dec_word;
   logic                 req_q;
   logic                 ack_stage_q;
   logic                 rd_q;
   logic                 hit_q;
   sehl_pkg::sehl_word_e index_q;
   // capture staging
   logic                 cap_q;
   logic                 dual_q;
   logic [31:0]          ad_lo_q;
   logic [31:0]          ad_hi_q;
   logic [3:0]           cbe_lo_q;
   logic [3:0]           cbe_hi_q;
   // output flops
   logic                 ack_q;
   logic [31:0]          rdata_q;
   logic                 unused_wdata;

   // map a byte offset to a log word, hit flag in the top bit
   function automatic logic [2:0] decode_word(input logic [11:0] a);
      logic [2:0] r;
      r = 3'b000;
      unique case (a)
         sehl_pkg::OFS_WORD0: r = {1'b1, sehl_pkg::WORD_ATTR};
         sehl_pkg::OFS_WORD1: r = {1'b1, sehl_pkg::WORD_CMD};
         sehl_pkg::OFS_WORD2: r = {1'b1, sehl_pkg::WORD_ALO};
         sehl_pkg::OFS_WORD3: r = {1'b1, sehl_pkg::WORD_AHI};
         default:             r = 3'b000;
      endcase
      return r;
   endfunction

   // either reset pin asserts the fundamental reset
   assign fundamental_reset_n = PLATFORM_RESET_N & GLOBAL_RESET_N;
   // access pipeline also drops on fundamental reset
   assign bus_rst_n = RESET_N & fundamental_reset_n;
   assign unused_wdata = ^CFG_WDATA;
   // offset decode shared by the hit flag and the word index
   assign dec_word = decode_word(CFG_ADDR);

   // capture strobe; fundamental reset only, so that a
   // function-level reset cannot lose an error in flight
   always_ff @(posedge CLK) begin
      if (!fundamental_reset_n) begin
         cap_q <= 1'b0;
      end else begin
         cap_q <= ERR_CAPTURE;
      end
   end

   // address width flag, sampled with the strobe
   always_ff @(posedge CLK) begin
      if (!fundamental_reset_n) begin
         dual_q <= 1'b0;
      end else begin
         dual_q <= ERR_DUAL;
      end
   end

   // first phase address
   always_ff @(posedge CLK) begin
      if (!fundamental_reset_n) begin
         ad_lo_q <= sehl_pkg::LOG_RESET;
      end else begin
         ad_lo_q <= ERR_AD_FIRST;
      end
   end

   // second phase address, dropped later for single cycles
   always_ff @(posedge CLK) begin
      if (!fundamental_reset_n) begin
         ad_hi_q <= sehl_pkg::LOG_RESET;
      end else begin
         ad_hi_q <= ERR_AD_SECOND;
      end
   end

   // first phase command
   always_ff @(posedge CLK) begin
      if (!fundamental_reset_n) begin
         cbe_lo_q <= sehl_pkg::CMD_RESET;
      end else begin
         cbe_lo_q <= ERR_CBE_FIRST;
      end
   end

   // second phase command, dropped later for single cycles
   always_ff @(posedge CLK) begin
      if (!fundamental_reset_n) begin
         cbe_hi_q <= sehl_pkg::CMD_RESET;
      end else begin
         cbe_hi_q <= ERR_CBE_SECOND;
      end
   end

   // request flag; reads and writes are both taken and
   // acknowledged, back to back if need be
   always_ff @(posedge CLK) begin
      if (!bus_rst_n) begin
         req_q <= 1'b0;
      end else begin
         req_q <= CFG_RD | CFG_WR;
      end
   end

   // read flag; read wins if both strobes come together,
   // and a lone write never reaches the store
   always_ff @(posedge CLK) begin
      if (!bus_rst_n) begin
         rd_q <= 1'b0;
      end else begin
         rd_q <= CFG_RD;
      end
   end

   // hit flag; offsets between or beside the log words
   // miss and read back zero
   always_ff @(posedge CLK) begin
      if (!bus_rst_n) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= dec_word[2];
      end
   end

   // word index for the store read mux
   always_ff @(posedge CLK) begin
      if (!bus_rst_n) begin
         index_q <= sehl_pkg::WORD_ATTR;
      end else begin
         index_q <= sehl_pkg::sehl_word_e'(dec_word[1:0]);
      end
   end

   // second stage waits for the registered store data
   always_ff @(posedge CLK) begin
      if (!bus_rst_n) begin
         ack_stage_q <= 1'b0;
      end else begin
         ack_stage_q <= req_q;
      end
   end

   // acknowledge, two edges after the take
   always_ff @(posedge CLK) begin
      if (!bus_rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_stage_q;
      end
   end

   // read data; zero outside the ack cycle because the store
   // idles its read register at zero, so misses and writes read zero
   always_ff @(posedge CLK) begin
      if (!bus_rst_n) begin
         rdata_q <= sehl_pkg::LOG_RESET;
      end else begin
         rdata_q <= lif.rd_data;
      end
   end

   // capture side of the store port; config writes never reach it
   assign lif.fundamental_reset_n_n     = fundamental_reset_n;
   assign lif.cap_valid  = cap_q;
   assign lif.cap_dual   = dual_q;
   assign lif.cap_ad_lo  = ad_lo_q;
   assign lif.cap_ad_hi  = ad_hi_q;
   assign lif.cap_cbe_lo = cbe_lo_q;
   assign lif.cap_cbe_hi = cbe_hi_q;
   // read side of the store port
   assign lif.rd_en      = req_q & rd_q & hit_q;
   assign lif.rd_index   = index_q;

   // log storage with registered read data
   sehl_log_store u_store (
      .CLK (CLK),
      .lif (lif.store)
   );

   // top outputs straight from flops
   assign CFG_ACK   = ack_q;
   assign CFG_RDATA = rdata_q;
endmodule

// >>> test/sehl_err_agent.sv
// far-side bus agent presenting one erroring bus cycle to the log
`timescale 1ns/1ns
module sehl_err_agent (
   input  wire logic        CLK,            // clock
   output logic             ERR_CAPTURE,    // error strobe
   output logic             ERR_DUAL,       // dual address cycle
   output logic [31:0]      ERR_AD_FIRST,   // first phase AD
   output logic [31:0]      ERR_AD_SECOND,  // second phase AD
   output logic [3:0]       ERR_CBE_FIRST,  // first phase C/BE
   output logic [3:0]       ERR_CBE_SECOND  // second phase C/BE
);
   // idle lines at time zero
   initial begin
      ERR_CAPTURE = 1'b0;
      {ERR_DUAL, ERR_AD_FIRST, ERR_AD_SECOND} = '0;
      {ERR_CBE_FIRST, ERR_CBE_SECOND} = 8'h00;
   end
   // one-cycle strobe; lines then invert so stale sampling shows up
   task automatic issue(logic d, logic [31:0] a1, a2, logic [3:0] c1, c2);
      ERR_CAPTURE = 1'b1;
      {ERR_DUAL, ERR_AD_FIRST, ERR_AD_SECOND} = {d, a1, a2};
      {ERR_CBE_FIRST, ERR_CBE_SECOND} = {c1, c2};
      @(negedge CLK);
      ERR_CAPTURE = 1'b0;
      {ERR_DUAL, ERR_AD_FIRST, ERR_AD_SECOND} = ~{d, a1, a2};
      {ERR_CBE_FIRST, ERR_CBE_SECOND} = ~{c1, c2};
   endtask
endmodule

// >>> test/sehl_header_log_assertions.sv
// port checker for the error header log
`timescale 1ns/1ns
module sehl_header_log_assertions (
   input wire logic        CLK,              // clock
   input wire logic        RESET_N,          // access reset
   input wire logic        PLATFORM_RESET_N, // platform reset
   input wire logic        GLOBAL_RESET_N,   // global reset
   input wire logic        ERR_CAPTURE,      // error strobe
   input wire logic        ERR_DUAL,         // dual cycle
   input wire logic [31:0] ERR_AD_FIRST,     // first phase AD
   input wire logic        CFG_RD,           // read strobe
   input wire logic        CFG_WR,           // write strobe
   input wire logic [11:0] CFG_ADDR,         // byte offset
   input wire logic        CFG_ACK,          // access done
   input wire logic [31:0] CFG_RDATA         // read data
);
   // any reset empties the access pipeline, so all checks pause
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N || !PLATFORM_RESET_N || !GLOBAL_RESET_N);
   property p_ack_lat;
      (CFG_RD || CFG_WR) |-> ##3 CFG_ACK;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_idle_zero;
      !CFG_ACK |-> CFG_RDATA == 32'h0000_0000;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("data idle");
   property p_word0;
      CFG_ACK && $past(CFG_ADDR, 3) == 12'h13c |-> CFG_RDATA == 32'h0;
   endproperty
   a_word0: assert property (p_word0) else $error("word0 not zero");
   property p_word1;
      CFG_ACK && $past(CFG_ADDR, 3) == 12'h140
         |-> CFG_RDATA[31:12] == 20'h0 && CFG_RDATA[3:0] == 4'h0;
   endproperty
   a_word1: assert property (p_word1) else $error("word1 reserved");
   property p_wr_zero;
      CFG_ACK && $past(CFG_WR, 3) && !$past(CFG_RD, 3) |-> CFG_RDATA == 0;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("write data");
   property p_unmapped;
      CFG_ACK && !($past(CFG_ADDR, 3) inside {12'h13c, 12'h140, 12'h144,
         12'h148}) |-> CFG_RDATA == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   property p_single_hi;
      ERR_CAPTURE && !ERR_DUAL ##1 !ERR_CAPTURE ##1 (!ERR_CAPTURE && CFG_RD
         && CFG_ADDR == 12'h148) |-> ##3 CFG_RDATA == 32'h0000_0000;
   endproperty
   a_single_hi: assert property (p_single_hi) else $error("hi addr");
   property p_ad_lo;
      ERR_CAPTURE ##1 !ERR_CAPTURE ##1 (!ERR_CAPTURE && CFG_RD
         && CFG_ADDR == 12'h144) |-> ##3 CFG_RDATA == $past(ERR_AD_FIRST, 5);
   endproperty
   a_ad_lo: assert property (p_ad_lo) else $error("lo addr");
endmodule
bind sehl_header_log sehl_header_log_assertions u_chk (.CLK, .RESET_N,
   .PLATFORM_RESET_N, .GLOBAL_RESET_N, .ERR_CAPTURE, .ERR_DUAL,
   .ERR_AD_FIRST, .CFG_RD, .CFG_WR, .CFG_ADDR, .CFG_ACK, .CFG_RDATA);

// >>> test/sehl_header_log_bench.sv
// self-checking bench for the error header log
`timescale 1ns/1ns
module sehl_header_log_bench;
   logic        clk = 1'b0, rst_n = 1'b0, prst_n = 1'b0, global_reset_n_n = 1'b0;
   logic        rd = 1'b0, wr = 1'b0, ack, cap, dual;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000, rdata, ad1, ad2;
   logic [3:0]  cbe1, cbe2;
   int          fails = 0, cmp_count = 0;
   always #5 clk = ~clk;
   sehl_err_agent agent (.CLK(clk), .ERR_CAPTURE(cap), .ERR_DUAL(dual),
      .ERR_AD_FIRST(ad1), .ERR_AD_SECOND(ad2), .ERR_CBE_FIRST(cbe1),
      .ERR_CBE_SECOND(cbe2));
   sehl_header_log dut (.CLK(clk), .RESET_N(rst_n), .PLATFORM_RESET_N(prst_n),
      .GLOBAL_RESET_N(global_reset_n_n), .ERR_CAPTURE(cap), .ERR_DUAL(dual),
      .ERR_AD_FIRST(ad1), .ERR_AD_SECOND(ad2), .ERR_CBE_FIRST(cbe1),
      .ERR_CBE_SECOND(cbe2), .CFG_RD(rd), .CFG_WR(wr), .CFG_ADDR(addr),
      .CFG_WDATA(wdata), .CFG_ACK(ack), .CFG_RDATA(rdata));
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask
   // one access from a falling edge; ack must land two edges after take
   task automatic acc(logic w, logic [11:0] a, logic [31:0] exp, string nm);
      int n;
      {rd, wr, addr, wdata} = {!w, w, a, 32'hffff_ffff};
      @(negedge clk);
      {rd, wr} = 2'b00;
      for (n = 0; n < 4 && ack !== 1'b1; n++)
         @(negedge clk);
      chk({nm, " latency"}, 32'd2, 32'(n));
      if (n == 4)
         test_done();
      chk(nm, exp, rdata);
   endtask
   task automatic s_reset();
      logic [11:0] ofs [6] = '{12'h13c, 12'h140, 12'h144, 12'h148, 12'h138,
                               12'h14c};
      foreach (ofs[i])
         acc(1'b0, ofs[i], 32'h0000_0000, "after reset");
   endtask
   task automatic s_dual();
      agent.issue(1'b1, 32'h1234_5678, 32'h9abc_def0, 4'hd, 4'hc);
      @(negedge clk);
      acc(1'b0, 12'h144, 32'h1234_5678, "dual lo");
      acc(1'b0, 12'h148, 32'h9abc_def0, "dual hi");
      acc(1'b0, 12'h140, 32'h0000_0cd0, "dual cmd");
      acc(1'b0, 12'h13c, 32'h0000_0000, "attr");
   endtask
   task automatic s_single();
      agent.issue(1'b0, 32'hcafe_0011, 32'hffff_ffff, 4'h6, 4'h7);
      @(negedge clk);
      acc(1'b0, 12'h148, 32'h0000_0000, "single hi");
      acc(1'b0, 12'h144, 32'hcafe_0011, "single lo");
      acc(1'b0, 12'h140, 32'h0000_0060, "single cmd");
      acc(1'b1, 12'h144, 32'h0000_0000, "write ack");
      acc(1'b0, 12'h144, 32'hcafe_0011, "after write");
   endtask
   // global, platform, then access reset; only the last keeps the log
   task automatic s_resets();
      int k;
      for (k = 0; k < 3; k++) begin
         agent.issue(1'b1, 32'h0bad_f00d, 32'h5555_aaaa, 4'h3, 4'h5);
         @(negedge clk);
         {rst_n, prst_n, global_reset_n_n} = ~(3'b001 << k);
         repeat (2) @(negedge clk);
         {rst_n, prst_n, global_reset_n_n} = 3'b111;
         acc(1'b0, 12'h148, (k == 2) ? 32'h5555_aaaa : 32'h0, "kept");
      end
   endtask
   initial begin
      repeat (8) @(negedge clk);
      {rst_n, prst_n, global_reset_n_n} = 3'b111;
      s_reset();
      s_dual();
      s_single();
      s_resets();
      test_done();
   end
endmodule
